// >>> rtl/fmpc_pkg.sv
// Package: register map, field layout, reset values and timing constants
// Function
// - Slot B subtract-cycle ADC results above threshold bump the exceed count.
// - Slot A LED choice 0 drives nothing, 1..3 drive LED one to three.
// - Slot B LED choice uses the same encoding as slot A.
// - Slot A pulse lasts width count microseconds; width resets to three.
// - Slot B pulse lasts width count microseconds; width resets to three.
// - Slot A first pulse delayed by offset microseconds; offset resets 0x20.
// - Slot B first pulse delayed by its own offset; resets to 0x20.
// - Slot B late pair signs: 00 add both, 10 sub third, 11 sub both.
// - Slot A late pair signs follow the same codes, every four pulses.
// - Slot B early pair signs: 00, 01, 10, 11 select add/subtract combos.
// - Slot A early pair signs use the same four codes every group.
// - Buffer enable bit sets integrator as buffer while in transimpedance mode.
// - Float mode runs only when the slot enable field equals three.
// - Slot B flag sets after 1, 4 or 16 exceedances; code 0 never.
// - Fire mask zero fires that pulse position, one suppresses it.
`default_nettype none
package fmpc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BKG_B = 8'h1c;
  localparam logic [7:0] ADDR_LED_A = 8'h3e;
  localparam logic [7:0] ADDR_LED_B = 8'h3f;
  localparam logic [7:0] ADDR_SIGN = 8'h58;
  localparam logic [7:0] ADDR_FLT_B = 8'h59;
  localparam logic [7:0] ADDR_FIRE = 8'h5a;
  localparam logic [7:0] ADDR_FLT_A = 8'h5e;
  // Reset values
  localparam logic [15:0] RST_LED = 16'h0320;
  localparam logic [15:0] RST_SIGN = 16'h0000;
  localparam logic [15:0] RST_BKG = 16'h0000;
  localparam logic [15:0] RST_FLT = 16'h0808;
  localparam logic [15:0] RST_FIRE = 16'h0010;
  localparam logic [15:0] RST_FLT_A = 16'h0000;
  // Field positions
  localparam int CHOICE_HI = 15;
  localparam int CHOICE_LO = 14;
  localparam int LEN_HI = 12;
  localparam int LEN_LO = 8;
  localparam int DLY_HI = 7;
  localparam int DLY_LO = 0;
  localparam int LATE_B_LO = 10;
  localparam int LATE_A_LO = 8;
  localparam int BUF_BIT = 7;
  localparam int EARLY_B_LO = 5;
  localparam int EARLY_A_LO = 1;
  localparam int FEN_HI = 14;
  localparam int FEN_LO = 13;
  localparam int FIRE_B_LO = 12;
  localparam int FIRE_A_LO = 8;
  localparam int CNT_HI = 15;
  localparam int CNT_LO = 14;
  localparam int THR_HI = 13;
  localparam int STATUS_FLAG_BIT = 4;
  localparam logic [1:0] FLOAT_ON = 2'h3;
  localparam logic [1:0] LATE_SUB3 = 2'h2;
  localparam logic [1:0] LATE_SUB34 = 2'h3;
  // Exceed count targets per count code
  localparam logic [4:0] TGT_1 = 5'h01;
  localparam logic [4:0] TGT_2 = 5'h04;
  localparam logic [4:0] TGT_3 = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_NS = 1000;
  localparam int CYC_PER_US = STEP_NS / CLK_PERIOD_NS;
  localparam logic [5:0] CYC_LAST = 6'(CYC_PER_US - 1);
  typedef enum logic [1:0] {
    FMPC_IDLE = 2'b00,
    FMPC_DELAY = 2'b01,
    FMPC_ON = 2'b10,
    FMPC_OFF = 2'b11
  } fmpc_state_t;
endpackage
`default_nettype wire

// >>> rtl/fmpc_pulse_seq.sv
// Module: per-slot float-mode LED pulse sequencer
`default_nettype none
module fmpc_pulse_seq
  import fmpc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Slot configuration and results
  fmpc_seq_if.seq sif
);
  fmpc_state_t state;
  fmpc_state_t next_state;
  logic [5:0] cyc;
  logic [7:0] units;
  logic [7:0] next_units;
  logic [7:0] pidx;
  logic [7:0] pidx_inc;
  logic tick;
  logic unit_done;
  logic fire;
  logic [2:0] choice_led;
  logic sign_now;

  assign tick = (cyc == CYC_LAST);
  assign unit_done = tick && (units <= 8'h01);
  assign pidx_inc = pidx + 8'h01;
  assign fire = !sif.fire_mask[pidx[1:0]];
  // One-hot LED from the choice code, zero selects none
  assign choice_led = (sif.choice == 2'h0) ? 3'h0 :
                      3'(3'h1 << (sif.choice - 2'h1));
  // Code 01 of the late pair falls through to add/add
  assign sign_now = (pidx[1:0] == 2'h0) ? sif.early[1] :
                    (pidx[1:0] == 2'h1) ? sif.early[0] :
                    (pidx[1:0] == 2'h2) ? (sif.late == LATE_SUB3 ||
                                           sif.late == LATE_SUB34) :
                    (sif.late == LATE_SUB34);

  always_comb begin
    next_state = state;
    next_units = units;
    unique case (state)
      FMPC_IDLE: begin
        if (sif.start && sif.enable) begin
          next_state = FMPC_DELAY;
          next_units = sif.delay;
        end
      end
      FMPC_DELAY: begin
        if (unit_done) begin
          next_state = FMPC_ON;
          next_units = 8'(sif.pulse_len);
        end else if (tick) begin
          next_units = units - 8'h01;
        end
      end
      FMPC_ON: begin
        if (unit_done) begin
          next_state = FMPC_OFF;
          next_units = 8'(sif.pulse_len);
        end else if (tick) begin
          next_units = units - 8'h01;
        end
      end
      FMPC_OFF: begin
        if (unit_done) begin
          next_state = (pidx >= sif.num_pulses) ? FMPC_IDLE : FMPC_ON;
          next_units = 8'(sif.pulse_len);
        end else if (tick) begin
          next_units = units - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= FMPC_IDLE;
      units <= 8'h00;
    end else begin
      state <= next_state;
      units <= next_units;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 6'h00;
    end else begin
      cyc <= (state == FMPC_IDLE || tick) ? 6'h00 : cyc + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pidx <= 8'h00;
    end else if (state == FMPC_IDLE) begin
      pidx <= 8'h00;
    end else if (state == FMPC_ON && unit_done) begin
      // Step at pulse end so the next pulse's first cycle sees its own mask bit
      pidx <= pidx_inc;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sif.led <= 3'h0;
      sif.strobe <= 1'b0;
      sif.subtract <= 1'b0;
    end else begin
      sif.led <= (next_state == FMPC_ON && fire) ? choice_led : 3'h0;
      sif.strobe <= (state == FMPC_ON) && unit_done;
      if ((state == FMPC_ON) && unit_done) begin
        sif.subtract <= sign_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [15:0] on_cyc;
  logic [15:0] dly_cyc;
  logic [15:0] len_cyc;
  logic [15:0] dly_want;
  assign len_cyc = 16'(((sif.pulse_len == 5'h00) ? 5'h01 : sif.pulse_len)
                   * CYC_PER_US);
  assign dly_want = 16'(((sif.delay == 8'h00) ? 8'h01 : sif.delay)
                    * CYC_PER_US);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_cyc <= 16'h0000;
      dly_cyc <= 16'h0000;
    end else begin
      on_cyc <= (state == FMPC_ON) ? on_cyc + 16'h0001 : 16'h0000;
      dly_cyc <= (state == FMPC_DELAY) ? dly_cyc + 16'h0001 : 16'h0000;
    end
  end

  a_pulse_width: assert property (@(posedge clock) disable iff (!rst_n)
    (state == FMPC_ON && next_state != FMPC_ON) |-> on_cyc + 16'h0001 == len_cyc)
    else $error("LED pulse width wrong");
  a_first_delay: assert property (@(posedge clock) disable iff (!rst_n)
    (state == FMPC_DELAY && next_state == FMPC_ON) |->
      dly_cyc + 16'h0001 == dly_want)
    else $error("first pulse delay wrong");
  a_led_in_on: assert property (@(posedge clock) disable iff (!rst_n)
    (sif.led != 3'h0) |-> (state == FMPC_ON && sif.choice != 2'h0))
    else $error("LED driven outside pulse");
  a_mask_blocks: assert property (@(posedge clock)
    disable iff (!rst_n)
    (state == FMPC_ON && sif.fire_mask[pidx[1:0]]) |-> sif.led == 3'h0)
    else $error("masked pulse fired");
  a_enable_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (state == FMPC_IDLE && !sif.enable) |=> state == FMPC_IDLE)
    else $error("sequence started while disabled");
  a_sign_late: assert property (@(posedge clock) disable iff (!rst_n)
    (state == FMPC_ON && unit_done && pidx[1:0] == 2'h3)
      |=> sif.subtract == $past(sif.late == LATE_SUB34))
    else $error("fourth sample sign wrong");
  a_sign_early: assert property (@(posedge clock) disable iff (!rst_n)
    (state == FMPC_ON && unit_done && pidx[1:0] == 2'h0)
      |=> sif.subtract == $past(sif.early[1]) && sif.strobe)
    else $error("first sample sign wrong");
endmodule
`default_nettype wire

// >>> rtl/fmpc_seq_if.sv
// Interface: configuration and results between top and pulse sequencer
`default_nettype none
interface fmpc_seq_if;
  logic enable;
  logic start;
  logic [1:0] choice;
  logic [4:0] pulse_len;
  logic [7:0] delay;
  logic [3:0] fire_mask;
  logic [1:0] early;
  logic [1:0] late;
  logic [7:0] num_pulses;
  logic [2:0] led;
  logic strobe;
  logic subtract;
  modport cfg (
    output enable, start, choice, pulse_len, delay, fire_mask, early, late,
    output num_pulses,
    input led, strobe, subtract
  );
  modport seq (
    input enable, start, choice, pulse_len, delay, fire_mask, early, late,
    input num_pulses,
    output led, strobe, subtract
  );
endinterface
`default_nettype wire

// >>> rtl/fmpc_top.sv
// Module: float-mode pulse configuration registers and background check
`default_nettype none
module fmpc_top
  import fmpc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Slot timing
  input wire logic slot_start_a,
  input wire logic slot_start_b,
  input wire logic [7:0] num_pulses,
  // Converter results
  input wire logic adc_valid_b,
  input wire logic [13:0] adc_result,
  input wire logic transimpedance_amp_mode,
  // Outputs
  output logic [2:0] led_drive,
  output logic sample_strobe_a,
  output logic sample_sub_a,
  output logic sample_strobe_b,
  output logic sample_sub_b,
  output logic integrator_buffer_on,
  output logic bkg_flag_slot_b
);
  logic [15:0] led_cfg_a;
  logic [15:0] led_cfg_b;
  logic [15:0] sign_cfg;
  logic [15:0] bkg_cfg;
  logic [15:0] flt_cfg_b;
  logic [15:0] fire_cfg;
  logic [15:0] flt_cfg_a;
  logic [4:0] bkg_exceed_count_slot_b;
  logic last_sub_b;

  fmpc_seq_if sif_a ();
  fmpc_seq_if sif_b ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic wr_led_a;
  logic wr_led_b;
  logic wr_sign;
  logic wr_bkg;
  logic wr_flt_b;
  logic wr_fire;
  logic wr_flt_a;
  logic rd_status;
  logic float_enable_slot_a;
  logic float_enable_slot_b;
  logic [13:0] bkg_threshold_slot_b;
  logic [1:0] cnt_code;
  logic exceed;
  logic [4:0] cnt_target;
  logic [4:0] cnt_inc;
  logic flag_hit;
  logic [15:0] next_rdata;

  assign wr_led_a = reg_wr && (reg_addr == ADDR_LED_A);
  assign wr_led_b = reg_wr && (reg_addr == ADDR_LED_B);
  assign wr_sign = reg_wr && (reg_addr == ADDR_SIGN);
  assign wr_bkg = reg_wr && (reg_addr == ADDR_BKG_B);
  assign wr_flt_b = reg_wr && (reg_addr == ADDR_FLT_B);
  assign wr_fire = reg_wr && (reg_addr == ADDR_FIRE);
  assign wr_flt_a = reg_wr && (reg_addr == ADDR_FLT_A);
  assign rd_status = reg_rd && (reg_addr == ADDR_STATUS);

  assign float_enable_slot_a = (flt_cfg_a[FEN_HI:FEN_LO] == FLOAT_ON);
  assign float_enable_slot_b = (flt_cfg_b[FEN_HI:FEN_LO] == FLOAT_ON);
  assign bkg_threshold_slot_b = bkg_cfg[THR_HI:0];
  assign cnt_code = bkg_cfg[CNT_HI:CNT_LO];
  // Compare only results taken during a slot B subtract sample
  assign exceed = adc_valid_b && last_sub_b && float_enable_slot_b &&
                  (adc_result > bkg_threshold_slot_b);
  assign cnt_target = (cnt_code == 2'h1) ? TGT_1 :
                      (cnt_code == 2'h2) ? TGT_2 : TGT_3;
  assign cnt_inc = (bkg_exceed_count_slot_b == CNT_MAX) ?
                   CNT_MAX : bkg_exceed_count_slot_b + 5'h01;
  assign flag_hit = exceed && (cnt_code != 2'h0) &&
                    (cnt_inc == cnt_target);

  assign next_rdata =
    (reg_addr == ADDR_STATUS) ? 16'(bkg_flag_slot_b) << STATUS_FLAG_BIT :
    (reg_addr == ADDR_BKG_B) ? bkg_cfg :
    (reg_addr == ADDR_LED_A) ? led_cfg_a :
    (reg_addr == ADDR_LED_B) ? led_cfg_b :
    (reg_addr == ADDR_SIGN) ? sign_cfg :
    (reg_addr == ADDR_FLT_B) ? flt_cfg_b :
    (reg_addr == ADDR_FIRE) ? fire_cfg :
    (reg_addr == ADDR_FLT_A) ? flt_cfg_a : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_cfg_a <= RST_LED;
      led_cfg_b <= RST_LED;
      sign_cfg <= RST_SIGN;
      bkg_cfg <= RST_BKG;
    end else begin
      if (wr_led_a) led_cfg_a <= reg_wdata;
      if (wr_led_b) led_cfg_b <= reg_wdata;
      if (wr_sign) sign_cfg <= reg_wdata;
      if (wr_bkg) bkg_cfg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flt_cfg_b <= RST_FLT;
      fire_cfg <= RST_FIRE;
      flt_cfg_a <= RST_FLT_A;
      reg_rdata <= 16'h0000;
    end else begin
      if (wr_flt_b) flt_cfg_b <= reg_wdata;
      if (wr_fire) fire_cfg <= reg_wdata;
      if (wr_flt_a) flt_cfg_a <= reg_wdata;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  // Exceed counter restarts when the flag is read away
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bkg_exceed_count_slot_b <= 5'h00;
      bkg_flag_slot_b <= 1'b0;
    end else begin
      if (exceed) begin
        bkg_exceed_count_slot_b <= cnt_inc;
      end else if (rd_status) begin
        bkg_exceed_count_slot_b <= 5'h00;
      end
      if (flag_hit) begin
        bkg_flag_slot_b <= 1'b1;
      end else if (rd_status) begin
        bkg_flag_slot_b <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_sub_b <= 1'b0;
      led_drive <= 3'h0;
      integrator_buffer_on <= 1'b0;
    end else begin
      if (sif_b.strobe) last_sub_b <= sif_b.subtract;
      led_drive <= sif_a.led | sif_b.led;
      integrator_buffer_on <= sign_cfg[BUF_BIT] &&
                              transimpedance_amp_mode;
    end
  end

  assign sample_strobe_a = sif_a.strobe;
  assign sample_sub_a = sif_a.subtract;
  assign sample_strobe_b = sif_b.strobe;
  assign sample_sub_b = sif_b.subtract;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencers
  assign sif_a.enable = float_enable_slot_a;
  assign sif_a.start = slot_start_a;
  assign sif_a.choice = led_cfg_a[CHOICE_HI:CHOICE_LO];
  assign sif_a.pulse_len = led_cfg_a[LEN_HI:LEN_LO];
  assign sif_a.delay = led_cfg_a[DLY_HI:DLY_LO];
  assign sif_a.fire_mask = fire_cfg[FIRE_A_LO+3:FIRE_A_LO];
  assign sif_a.early = sign_cfg[EARLY_A_LO+1:EARLY_A_LO];
  assign sif_a.late = sign_cfg[LATE_A_LO+1:LATE_A_LO];
  assign sif_a.num_pulses = num_pulses;

  assign sif_b.enable = float_enable_slot_b;
  assign sif_b.start = slot_start_b;
  assign sif_b.choice = led_cfg_b[CHOICE_HI:CHOICE_LO];
  assign sif_b.pulse_len = led_cfg_b[LEN_HI:LEN_LO];
  assign sif_b.delay = led_cfg_b[DLY_HI:DLY_LO];
  assign sif_b.fire_mask = fire_cfg[FIRE_B_LO+3:FIRE_B_LO];
  assign sif_b.early = sign_cfg[EARLY_B_LO+1:EARLY_B_LO];
  assign sif_b.late = sign_cfg[LATE_B_LO+1:LATE_B_LO];
  assign sif_b.num_pulses = num_pulses;

  fmpc_pulse_seq u_seq_a (
    .clock(clock),
    .rst_n(rst_n),
    .sif(sif_a)
  );
  fmpc_pulse_seq u_seq_b (
    .clock(clock),
    .rst_n(rst_n),
    .sif(sif_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_exceed_counts: assert property (@(posedge clock) disable iff (!rst_n)
    (exceed && bkg_exceed_count_slot_b != CNT_MAX)
      |=> bkg_exceed_count_slot_b == $past(bkg_exceed_count_slot_b) + 5'h01)
    else $error("exceed count did not step");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (bkg_flag_slot_b && !rd_status) |=> bkg_flag_slot_b)
    else $error("flag dropped without read");
  a_flag_code0: assert property (@(posedge clock) disable iff (!rst_n)
    (cnt_code == 2'h0 && !bkg_flag_slot_b) |=> !bkg_flag_slot_b)
    else $error("flag set with count code zero");
  a_buffer_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (sign_cfg[BUF_BIT] && transimpedance_amp_mode)[*2] |-> integrator_buffer_on)
    else $error("integrator buffer not enabled");
endmodule
`default_nettype wire

// >>> test/fmpc_afe_model.sv
// Partner model: photodiode front end answering slot B sample strobes
`default_nettype none
module fmpc_afe_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Sample request and behaviour
  input wire logic strobe,
  input wire logic [3:0] lag,
  input wire logic [13:0] light,
  // Converter result
  output logic adc_valid,
  output logic [13:0] adc_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  initial begin
    adc_valid = 1'b0;
    adc_result = 14'h0;
    wait_cnt = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Result follows the strobe after lag cycles; stale data is inverted
  always @(negedge clock) begin
    adc_valid <= 1'b0;
    if (adc_valid) adc_result <= ~adc_result;
    if (!rst_n) wait_cnt <= 0;
    else if (strobe === 1'b1) wait_cnt <= int'(lag);
    else if (wait_cnt == 1) begin
      adc_valid <= 1'b1;
      adc_result <= light;
      wait_cnt <= 0;
    end
    else if (wait_cnt > 1) wait_cnt <= wait_cnt - 1;
  end
endmodule
`default_nettype wire

// >>> test/test_float_mode_pulse_config.sv
// Testbench: float-mode pulse configuration block
`default_nettype none
module test_float_mode_pulse_config
  import fmpc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, reg_wr, reg_rd, slot_start_a, slot_start_b;
  logic transimpedance_amp_mode, adc_valid_b, integrator_buffer_on;
  logic sample_strobe_a, sample_sub_a, sample_strobe_b, sample_sub_b;
  logic bkg_flag_slot_b;
  logic [7:0] reg_addr, num_pulses, dly;
  logic [15:0] reg_wdata, reg_rdata, rnd, q, d;
  logic [13:0] adc_result, light, thr;
  logic [2:0] led_drive, leds;
  logic [3:0] lag, mask, subs, fired;
  logic [4:0] len;
  logic [1:0] c;
  int failures, total_checks, cycles, i, b, n, t_rise, t_on;
  logic [7:0] addrs [4] = '{ADDR_LED_A, ADDR_LED_B, ADDR_SIGN, ADDR_BKG_B};
  logic [15:0] masks [4] = '{16'hdfff, 16'hdfff, 16'h0fe6, 16'hffff};
  logic [1:0] bc [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
  logic bd [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic bf [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  fmpc_top u_dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slot_start_a(slot_start_a),
    .slot_start_b(slot_start_b), .num_pulses(num_pulses),
    .adc_valid_b(adc_valid_b), .adc_result(adc_result),
    .transimpedance_amp_mode(transimpedance_amp_mode),
    .led_drive(led_drive), .sample_strobe_a(sample_strobe_a),
    .sample_sub_a(sample_sub_a), .sample_strobe_b(sample_strobe_b),
    .sample_sub_b(sample_sub_b),
    .integrator_buffer_on(integrator_buffer_on),
    .bkg_flag_slot_b(bkg_flag_slot_b)
  );
  fmpc_afe_model u_afe (
    .clock(clock), .rst_n(rst_n), .strobe(sample_strobe_b), .lag(lag),
    .light(light), .adc_valid(adc_valid_b), .adc_result(adc_result)
  );
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [3:0] exp_sub(input logic [1:0] k);
    return {k == 2'h3, k[1], k[0], k[1]};
  endfunction
  function automatic logic [2:0] exp_led(input logic [1:0] k);
    return {k == 2'h3, k == 2'h2, k == 2'h1};
  endfunction
  // Start edge to LED pin: one cycle in the sequencer, one in the output flop
  function automatic int exp_rise(input logic [7:0] k);
    return CYC_PER_US * (k == 8'h00 ? 1 : int'(k)) + 2;
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  // Starts one slot and records rise time, first width, LEDs and signs
  task automatic run(input int sb, input int lim);
    logic on;
    on = 1'b0;
    t_rise = 0;
    t_on = 0;
    n = 0;
    leds = 3'h0;
    subs = 4'h0;
    fired = 4'h0;
    @(negedge clock);
    if (sb == 1) slot_start_b = 1'b1;
    else slot_start_a = 1'b1;
    @(negedge clock);
    slot_start_a = 1'b0;
    slot_start_b = 1'b0;
    for (int k = 1; k < lim && n < 4; k++) begin
      if (led_drive !== 3'h0) begin
        leds = leds | led_drive;
        on = 1'b1;
        if (t_rise == 0) t_rise = k;
        if (n == 0) t_on++;
      end
      if ((sb == 1 ? sample_strobe_b : sample_strobe_a) === 1'b1) begin
        subs[n] = sb == 1 ? sample_sub_b : sample_sub_a;
        fired[n] = on;
        on = 1'b0;
        n++;
      end
      @(negedge clock);
    end
    repeat (100) @(negedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, slot_start_a, slot_start_b} = 5'h0;
    {reg_addr, reg_wdata, light, transimpedance_amp_mode} = 39'h0;
    num_pulses = 8'h04;
    lag = 4'h1;
    rnd = 16'h0027;
    {failures, total_checks, cycles} = 96'h0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    rd(ADDR_LED_A, q);
    check("slot a led reset", q, 16'h0320);
    rd(ADDR_LED_B, q);
    check("slot b led reset", q, 16'h0320);
    rd(ADDR_SIGN, q);
    check("sign reset", q, 16'h0000);
    rd(ADDR_BKG_B, q);
    check("threshold reset", q, 16'h0000);
    rd(8'h10, q);
    check("unmapped", q, 16'h0000);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d = rnd & masks[i % 4];
      wr(addrs[i % 4], d);
      rd(addrs[i % 4], q);
      check("readback", q, d);
    end
    $display("register test done");
    wr(ADDR_FLT_A, 16'h6000);
    wr(ADDR_FLT_B, 16'h6808);
    for (b = 0; b < 2; b++) begin
      for (i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        len = 5'h1 + 5'(rnd[0]);
        dly = 8'(rnd[2:1]);
        mask = rnd[6:3] & 4'he;
        c = 2'(i);
        wr(b == 1 ? ADDR_LED_B : ADDR_LED_A, {c, 1'b0, len, dly});
        wr(ADDR_SIGN, b == 1 ? {4'h0, c, 3'h0, c, 5'h0}
                             : {6'h0, c, 5'h0, c, 1'b0});
        wr(ADDR_FIRE, b == 1 ? {mask, 4'h0, 8'h10} : {4'h0, mask, 8'h10});
        run(b, 2000);
        check("strobes", n, 4);
        check("led choice", leds, exp_led(c));
        check("fired", fired, c == 2'h0 ? 4'h0 : mask ^ 4'hf);
        check("signs", subs, exp_sub(c));
        if (c != 2'h0) begin
          check("first pulse", t_rise, exp_rise(dly));
          check("width", t_on, CYC_PER_US * len);
        end
        $display("sequence slot %0d code %0d done", b, i);
      end
    end
    wr(ADDR_FLT_B, 16'h2808);
    run(1, 300);
    check("disabled strobes", n, 0);
    check("disabled led", leds, 3'h0);
    wr(ADDR_FLT_B, 16'h6808);
    $display("disable test done");
    wr(ADDR_LED_B, 16'h4100);
    wr(ADDR_FIRE, 16'h0010);
    for (i = 0; i < 6; i++) begin
      // Last pass adds every sample, so no exceedance may count
      wr(ADDR_SIGN, i == 5 ? 16'h0000 : 16'h0c60);
      rnd = lfsr(rnd);
      lag = i % 2 == 1 ? 4'h6 : 4'h1;
      thr = {1'b0, rnd[12:0]};
      light = thr + 14'(bd[i]);
      rd(ADDR_STATUS, q);
      wr(ADDR_BKG_B, {bc[i], thr});
      run(1, 2000);
      check("bkg flag", bkg_flag_slot_b, bf[i]);
      rd(ADDR_STATUS, q);
      check("status", q, {11'h0, bf[i], 4'h0});
      check("flag cleared", bkg_flag_slot_b, 1'b0);
    end
    $display("background test done");
    for (i = 0; i < 4; i++) begin
      transimpedance_amp_mode = i % 2 == 1;
      wr(ADDR_SIGN, {8'h0, i > 1, 7'h0});
      @(negedge clock);
      check("int buffer", integrator_buffer_on, i == 3);
    end
    $display("buffer test done");
    results();
  end
endmodule
`default_nettype wire
